// File: design/rut_cnt.v
/*
  Retirement event counter: counts one per increment pulse, cleared by
  software. Assumes single clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module rut_cnt #(
  parameter WIDTH = 32
) (
  input  wire             clk_sys_i,
  input  wire             nrst_i,
  input  wire             inc_i,
  input  wire             clr_i,
  output wire [WIDTH-1:0] value_o
);

  reg [WIDTH-1:0] cnt_r;
  reg [WIDTH-1:0] cnt_nxt;

  // ----------------------------------------------------------------------
  // Count; a same-cycle clear and increment load one so no event is lost
  // ----------------------------------------------------------------------
  always @* begin
    cnt_nxt = cnt_r;
    if (clr_i && inc_i) begin
      cnt_nxt = {{(WIDTH-1){1'b0}}, 1'b1};
    end else if (clr_i) begin
      cnt_nxt = {WIDTH{1'b0}};
    end else if (inc_i) begin
      cnt_nxt = cnt_r + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= {WIDTH{1'b0}};
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign value_o = cnt_r;

endmodule

`default_nettype wire

// File: design/rut_regs.vh
/*
  Register offsets, field positions and reset values of the retirement
  micro-op tagging block. Assumes byte addresses on a 32-bit word port.
*/
`ifndef RUT_REGS_VH
`define RUT_REGS_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RUT_OFS_SAMPLE_EN    8'h00
`define RUT_OFS_DIR_MATRIX   8'h04
`define RUT_OFS_UOP_KIND     8'h08
`define RUT_OFS_ADDR_SEL_A   8'h0C
`define RUT_OFS_ADDR_SEL_B   8'h10
`define RUT_OFS_REPLAY_SEL   8'h14
`define RUT_OFS_EXEC_UP      8'h18
`define RUT_OFS_EXEC_DOWN    8'h1C
`define RUT_OFS_CNT_REPLAY   8'h20
`define RUT_OFS_CNT_FE       8'h24
`define RUT_OFS_CNT_EXEC     8'h28

// ----------------------------------------------------------------------
// Reset value of every control register
// ----------------------------------------------------------------------
`define RUT_RST_VAL          32'h0000_0000

// ----------------------------------------------------------------------
// Sampling tag enable fields
// ----------------------------------------------------------------------
`define RUT_SE_L1_MISS       0
`define RUT_SE_L2_MISS       1
`define RUT_SE_DTLB_MISS     2
`define RUT_SE_MOB_REPLAY    9
`define RUT_SE_SPLIT         10
`define RUT_SE_GATE_A        24
`define RUT_SE_GATE_B        25

// ----------------------------------------------------------------------
// Direction matrix and micro-op kind fields
// ----------------------------------------------------------------------
`define RUT_DM_LOADS         0
`define RUT_DM_STORES        1
`define RUT_UK_LOAD_TAG      0
`define RUT_UK_STORE_TAG     1

// ----------------------------------------------------------------------
// Event select fields (address, replay, execution)
// ----------------------------------------------------------------------
`define RUT_ES_EVT_LSB       0
`define RUT_ES_EVT_MSB       5
`define RUT_ES_QUAL_A        8
`define RUT_ES_UNALIGNED     9
`define RUT_ES_SPLIT_LOAD    10
`define RUT_ES_SPLIT_STORE   11
`define RUT_ES_NONSPEC       12
`define RUT_EVT_MOB_REPLAY   6'h03
`define RUT_EVT_LOAD_PORT    6'h04
`define RUT_EVT_STORE_PORT   6'h05

`define RUT_EU_CLASS_LSB     0
`define RUT_EU_CLASS_MSB     2
`define RUT_EU_ALL           4
`define RUT_EU_PORT0         5
`define RUT_EU_PORT2         6
`define RUT_EU_TAG_EN        8
`define RUT_EU_TVAL_LSB      9
`define RUT_EU_TVAL_MSB      12
`define RUT_ED_NONSPEC       0
`define RUT_ED_MASK_LSB      4
`define RUT_ED_MASK_MSB      7

// ----------------------------------------------------------------------
// Execution class codes
// ----------------------------------------------------------------------
`define RUT_CLS_MOVES        3'h7

`endif

// File: design/rut_top.v
/*
  Retirement micro-op tagging: marks micro-ops at issue with replay,
  front-end and execution tags and counts them at retirement.
  Assumes the pipeline carries the tags from issue to retirement and
  returns them on the retirement port; registers on a simple word port.
*/
`timescale 1ns/1ps
`default_nettype none
`include "rut_regs.vh"

module rut_top #(
  parameter CNT_W = 32
) (
  input  wire             clk_sys_i,
  input  wire             nrst_i,
  input  wire [7:0]       reg_addr_i,
  input  wire [31:0]      reg_wdata_i,
  input  wire             reg_wr_i,
  input  wire             reg_rd_i,
  output reg  [31:0]      reg_rdata_o,
  input  wire             iss_valid_i,
  input  wire             iss_load_i,
  input  wire             iss_store_i,
  input  wire             iss_l1_miss_i,
  input  wire             iss_l2_miss_i,
  input  wire             iss_dtlb_miss_i,
  input  wire             iss_mob_replay_i,
  input  wire             iss_split_i,
  input  wire             iss_io_i,
  input  wire             iss_uncached_i,
  input  wire             iss_locked_i,
  input  wire             iss_return_i,
  input  wire             iss_far_i,
  input  wire             iss_exec_i,
  input  wire [2:0]       iss_class_i,
  input  wire             iss_port0_i,
  input  wire             iss_port2_i,
  output reg              tag_valid_o,
  output reg              tag_replay_o,
  output reg              tag_fe_o,
  output reg              tag_exec_o,
  output reg  [3:0]       tag_value_o,
  input  wire             ret_valid_i,
  input  wire             ret_nonspec_i,
  input  wire             ret_replay_i,
  input  wire             ret_fe_i,
  input  wire             ret_exec_i,
  input  wire [3:0]       ret_value_i,
  input  wire             fp_stack_fault_i
);

  // ----------------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------------
  reg  [31:0]      sample_en_r;
  reg  [31:0]      dir_matrix_r;
  reg  [31:0]      uop_kind_r;
  reg  [31:0]      addr_sel_a_r;
  reg  [31:0]      addr_sel_b_r;
  reg  [31:0]      replay_sel_r;
  reg  [31:0]      exec_up_r;
  reg  [31:0]      exec_down_r;
  wire [CNT_W-1:0] cnt_replay;
  wire [CNT_W-1:0] cnt_fe;
  wire [CNT_W-1:0] cnt_exec;

  function wr_hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = reg_wr_i && (addr == ofs);
    end
  endfunction

  function [31:0] cnt_word;
    input [CNT_W-1:0] val;
    begin
      cnt_word = 32'h0000_0000;
      cnt_word[CNT_W-1:0] = val;
    end
  endfunction

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sample_en_r  <= `RUT_RST_VAL;
      dir_matrix_r <= `RUT_RST_VAL;
      uop_kind_r   <= `RUT_RST_VAL;
      addr_sel_a_r <= `RUT_RST_VAL;
      addr_sel_b_r <= `RUT_RST_VAL;
      replay_sel_r <= `RUT_RST_VAL;
      exec_up_r    <= `RUT_RST_VAL;
      exec_down_r  <= `RUT_RST_VAL;
    end else begin
      if (wr_hit(reg_addr_i, `RUT_OFS_SAMPLE_EN)) begin
        sample_en_r <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, `RUT_OFS_DIR_MATRIX)) begin
        dir_matrix_r <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, `RUT_OFS_UOP_KIND)) begin
        uop_kind_r <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, `RUT_OFS_ADDR_SEL_A)) begin
        addr_sel_a_r <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, `RUT_OFS_ADDR_SEL_B)) begin
        addr_sel_b_r <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, `RUT_OFS_REPLAY_SEL)) begin
        replay_sel_r <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, `RUT_OFS_EXEC_UP)) begin
        exec_up_r <= reg_wdata_i;
      end
      if (wr_hit(reg_addr_i, `RUT_OFS_EXEC_DOWN)) begin
        exec_down_r <= reg_wdata_i;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read port; data stand only in the cycle after the strobe
  // ----------------------------------------------------------------------
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h0000_0000;
    case (reg_addr_i)
      `RUT_OFS_SAMPLE_EN:  rd_mux = sample_en_r;
      `RUT_OFS_DIR_MATRIX: rd_mux = dir_matrix_r;
      `RUT_OFS_UOP_KIND:   rd_mux = uop_kind_r;
      `RUT_OFS_ADDR_SEL_A: rd_mux = addr_sel_a_r;
      `RUT_OFS_ADDR_SEL_B: rd_mux = addr_sel_b_r;
      `RUT_OFS_REPLAY_SEL: rd_mux = replay_sel_r;
      `RUT_OFS_EXEC_UP:    rd_mux = exec_up_r;
      `RUT_OFS_EXEC_DOWN:  rd_mux = exec_down_r;
      `RUT_OFS_CNT_REPLAY: rd_mux = cnt_word(cnt_replay);
      `RUT_OFS_CNT_FE:     rd_mux = cnt_word(cnt_fe);
      `RUT_OFS_CNT_EXEC:   rd_mux = cnt_word(cnt_exec);
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Replay tag at issue
  // ----------------------------------------------------------------------
  wire untaggable = iss_io_i | iss_uncached_i | iss_locked_i | iss_return_i | iss_far_i;
  wire se_gate    = sample_en_r[`RUT_SE_GATE_A] & sample_en_r[`RUT_SE_GATE_B];
  wire dir_ok     = (dir_matrix_r[`RUT_DM_LOADS] & iss_load_i) |
                    (dir_matrix_r[`RUT_DM_STORES] & iss_store_i);
  // MOB and split causes also need the matching event select set up
  wire mob_sel    = (replay_sel_r[`RUT_ES_EVT_MSB:`RUT_ES_EVT_LSB] == `RUT_EVT_MOB_REPLAY) &
                    replay_sel_r[`RUT_ES_QUAL_A] & replay_sel_r[`RUT_ES_UNALIGNED];
  wire split_load_qualifier   = (addr_sel_b_r[`RUT_ES_EVT_MSB:`RUT_ES_EVT_LSB] == `RUT_EVT_LOAD_PORT) &
                    addr_sel_b_r[`RUT_ES_SPLIT_LOAD] & iss_load_i;
  wire split_store_qualifier   = (addr_sel_a_r[`RUT_ES_EVT_MSB:`RUT_ES_EVT_LSB] == `RUT_EVT_STORE_PORT) &
                    addr_sel_a_r[`RUT_ES_SPLIT_STORE] & iss_store_i;
  wire cause      = (sample_en_r[`RUT_SE_L1_MISS] & iss_l1_miss_i) |
                    (sample_en_r[`RUT_SE_L2_MISS] & iss_l2_miss_i) |
                    (sample_en_r[`RUT_SE_DTLB_MISS] & iss_dtlb_miss_i) |
                    (sample_en_r[`RUT_SE_MOB_REPLAY] & iss_mob_replay_i & mob_sel) |
                    (sample_en_r[`RUT_SE_SPLIT] & iss_split_i & (split_load_qualifier | split_store_qualifier));
  wire replay_tag = se_gate & cause & dir_ok & ~untaggable;

  // ----------------------------------------------------------------------
  // Front-end and execution tags at issue
  // ----------------------------------------------------------------------
  wire fe_tag = (uop_kind_r[`RUT_UK_LOAD_TAG] & iss_load_i) |
                (uop_kind_r[`RUT_UK_STORE_TAG] & iss_store_i);

  wire [2:0] up_class = exec_up_r[`RUT_EU_CLASS_MSB:`RUT_EU_CLASS_LSB];
  wire       is_moves = (up_class == `RUT_CLS_MOVES);
  wire       cls_mask = is_moves ?
                        ((exec_up_r[`RUT_EU_PORT0] & iss_port0_i) | (exec_up_r[`RUT_EU_PORT2] & iss_port2_i)) :
                        exec_up_r[`RUT_EU_ALL];
  wire exec_tag = iss_exec_i & (iss_class_i == up_class) & cls_mask & exec_up_r[`RUT_EU_TAG_EN];

  always @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tag_valid_o  <= 1'b0;
      tag_replay_o <= 1'b0;
      tag_fe_o     <= 1'b0;
      tag_exec_o   <= 1'b0;
      tag_value_o  <= 4'h0;
    end else begin
      tag_valid_o  <= iss_valid_i;
      tag_replay_o <= iss_valid_i & replay_tag;
      tag_fe_o     <= iss_valid_i & fe_tag;
      tag_exec_o   <= iss_valid_i & exec_tag;
      tag_value_o  <= (iss_valid_i & exec_tag) ? exec_up_r[`RUT_EU_TVAL_MSB:`RUT_EU_TVAL_LSB] : 4'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Retirement counting
  // ----------------------------------------------------------------------
  wire ret_ok     = ret_valid_i & ret_nonspec_i;
  wire inc_replay = ret_ok & ret_replay_i & replay_sel_r[`RUT_ES_NONSPEC];
  // Stack fault drops the front-end count; accepted undercount
  wire inc_fe     = ret_ok & ret_fe_i & ~fp_stack_fault_i;
  wire inc_exec   = ret_ok & ret_exec_i & exec_down_r[`RUT_ED_NONSPEC] &
                    (|(ret_value_i & exec_down_r[`RUT_ED_MASK_MSB:`RUT_ED_MASK_LSB]));

  rut_cnt #(
    .WIDTH   (CNT_W)
  ) u_cnt_replay (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .inc_i     (inc_replay),
    .clr_i     (wr_hit(reg_addr_i, `RUT_OFS_CNT_REPLAY)),
    .value_o   (cnt_replay)
  );

  rut_cnt #(
    .WIDTH   (CNT_W)
  ) u_cnt_fe (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .inc_i     (inc_fe),
    .clr_i     (wr_hit(reg_addr_i, `RUT_OFS_CNT_FE)),
    .value_o   (cnt_fe)
  );

  rut_cnt #(
    .WIDTH   (CNT_W)
  ) u_cnt_exec (
    .clk_sys_i (clk_sys_i),
    .nrst_i    (nrst_i),
    .inc_i     (inc_exec),
    .clr_i     (wr_hit(reg_addr_i, `RUT_OFS_CNT_EXEC)),
    .value_o   (cnt_exec)
  );

endmodule

`default_nettype wire

// File: tb/rut_checker.sv
/*
  Concurrent checks on the issue-side tag outputs of the tagging block.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none

module rut_checker (
  input wire logic       clk_sys_i,
  input wire logic       nrst_i,
  input wire logic       iss_valid_i,
  input wire logic       iss_load_i,
  input wire logic       iss_store_i,
  input wire logic       iss_l1_miss_i,
  input wire logic       iss_l2_miss_i,
  input wire logic       iss_dtlb_miss_i,
  input wire logic       iss_mob_replay_i,
  input wire logic       iss_split_i,
  input wire logic       iss_io_i,
  input wire logic       iss_uncached_i,
  input wire logic       iss_locked_i,
  input wire logic       iss_return_i,
  input wire logic       iss_far_i,
  input wire logic       iss_exec_i,
  input wire logic       tag_valid_o,
  input wire logic       tag_replay_o,
  input wire logic       tag_fe_o,
  input wire logic       tag_exec_o,
  input wire logic [3:0] tag_value_o
);
  // ----------------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!nrst_i);

  sequence s_nevertag;
    iss_valid_i && (iss_io_i || iss_uncached_i || iss_locked_i || iss_return_i || iss_far_i);
  endsequence
  sequence s_idle;
    !iss_valid_i;
  endsequence

  property p_never; s_nevertag |=> !tag_replay_o; endproperty
  property p_valid; iss_valid_i |=> tag_valid_o; endproperty
  property p_idle; s_idle |=> !(tag_replay_o || tag_fe_o || tag_exec_o); endproperty
  property p_cause;
    tag_replay_o |-> $past(iss_l1_miss_i || iss_l2_miss_i || iss_dtlb_miss_i || iss_mob_replay_i || iss_split_i);
  endproperty
  property p_dir; tag_replay_o |-> $past(iss_load_i || iss_store_i); endproperty
  property p_fe; tag_fe_o |-> $past(iss_load_i || iss_store_i); endproperty
  property p_exec; tag_exec_o |-> $past(iss_exec_i) && $past(iss_valid_i); endproperty
  property p_value; !tag_exec_o |-> tag_value_o == 4'h0; endproperty

  a_never: assert property (p_never) else $error("replay tag on excluded op");
  a_valid: assert property (p_valid) else $error("tag valid missing");
  a_idle:  assert property (p_idle) else $error("tag without issue");
  a_cause: assert property (p_cause) else $error("replay tag without cause");
  a_dir:   assert property (p_dir) else $error("replay tag without direction");
  a_fe:    assert property (p_fe) else $error("front-end tag on non-memory op");
  a_exec:  assert property (p_exec) else $error("exec tag without exec op");
  a_value: assert property (p_value) else $error("tag value without exec tag");
endmodule

bind rut_top rut_checker u_chk (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .iss_valid_i(iss_valid_i),
  .iss_load_i(iss_load_i), .iss_store_i(iss_store_i), .iss_l1_miss_i(iss_l1_miss_i),
  .iss_l2_miss_i(iss_l2_miss_i), .iss_dtlb_miss_i(iss_dtlb_miss_i), .iss_mob_replay_i(iss_mob_replay_i),
  .iss_split_i(iss_split_i), .iss_io_i(iss_io_i), .iss_uncached_i(iss_uncached_i),
  .iss_locked_i(iss_locked_i), .iss_return_i(iss_return_i), .iss_far_i(iss_far_i),
  .iss_exec_i(iss_exec_i), .tag_valid_o(tag_valid_o), .tag_replay_o(tag_replay_o),
  .tag_fe_o(tag_fe_o), .tag_exec_o(tag_exec_o), .tag_value_o(tag_value_o));
`default_nettype wire

// File: tb/testbench.sv
/*
  Self-checking bench of the tagging block: register port, issue tags and
  retirement counters. Assumes the design's own register offsets.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end

module testbench;
  // ----------------------------------------------------------------------
  // Stimulus and hookup
  // ----------------------------------------------------------------------
  logic        clk, nrst, wr, rd, fault, tv, tr, tf, te;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [15:0] iss;
  logic [2:0]  cls;
  logic [4:0]  ret;
  logic [3:0]  rval, tval;
  int          n_mismatch, tests_run, k;

  rut_top dut (.clk_sys_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .iss_valid_i(iss[0]), .iss_load_i(iss[1]),
    .iss_store_i(iss[2]), .iss_l1_miss_i(iss[3]), .iss_l2_miss_i(iss[4]), .iss_dtlb_miss_i(iss[5]),
    .iss_mob_replay_i(iss[6]), .iss_split_i(iss[7]), .iss_io_i(iss[8]), .iss_uncached_i(iss[9]),
    .iss_locked_i(iss[10]), .iss_return_i(iss[11]), .iss_far_i(iss[12]), .iss_exec_i(iss[13]),
    .iss_class_i(cls), .iss_port0_i(iss[14]), .iss_port2_i(iss[15]), .tag_valid_o(tv),
    .tag_replay_o(tr), .tag_fe_o(tf), .tag_exec_o(te), .tag_value_o(tval), .ret_valid_i(ret[0]),
    .ret_nonspec_i(ret[1]), .ret_replay_i(ret[2]), .ret_fe_i(ret[3]), .ret_exec_i(ret[4]),
    .ret_value_i(rval), .fp_stack_fault_i(fault));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------------
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 `CHK(rdata, e)
  endtask
  // Expected tags packed as {replay, fe, exec}
  task automatic issue(input logic [15:0] f, input logic [2:0] c, input logic [2:0] e);
    @(posedge clk); iss <= f | 16'h0001; cls <= c;
    @(posedge clk); iss <= 16'h0000;
    #1 `CHK({tv, tr, tf, te}, {1'b1, e})
  endtask
  task automatic retire(input logic [4:0] f, input logic [3:0] v, input logic flt);
    @(posedge clk); ret <= f; rval <= v; fault <= flt;
    @(posedge clk); ret <= 5'h00; fault <= 1'b0;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    n_mismatch = 0; tests_run = 0; nrst = 1'b0; wr = 1'b0; rd = 1'b0; addr = 8'h00;
    wdata = 32'h0; iss = 16'h0; cls = 3'h0; ret = 5'h00; rval = 4'h0; fault = 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    for (k = 0; k <= 8'h28; k += 4) rreg(k[7:0], 32'h0);
    rreg(8'h3C, 32'h0);
    $display("test reset done");
    wreg(8'h08, 32'h1);
    issue(16'h0002, 3'h0, 3'b010);
    issue(16'h0004, 3'h0, 3'b000);
    wreg(8'h08, 32'h2);
    issue(16'h0004, 3'h0, 3'b010);
    issue(16'h0002, 3'h0, 3'b000);
    $display("test front-end tags done");
    // Front-end tagging off so load and store ops below show only replay tags
    wreg(8'h08, 32'h0);
    wreg(8'h04, 32'h1);
    for (k = 0; k < 3; k++) begin
      wreg(8'h00, 32'h0300_0000 | (32'h1 << k));
      issue(16'h0002 | (16'h8 << k), 3'h0, 3'b100);
    end
    // Enabled cause present, so only the excluded kind blocks the tag
    for (k = 8; k < 13; k++) issue(16'h0022 | (16'h1 << k), 3'h0, 3'b000);
    issue(16'h0024, 3'h0, 3'b000);
    wreg(8'h00, 32'h0100_0001);
    issue(16'h000A, 3'h0, 3'b000);
    wreg(8'h00, 32'h0300_0400);
    issue(16'h0082, 3'h0, 3'b000);
    wreg(8'h10, 32'h404);
    issue(16'h0082, 3'h0, 3'b100);
    wreg(8'h04, 32'h3);
    issue(16'h0084, 3'h0, 3'b000);
    wreg(8'h0C, 32'h805);
    issue(16'h0084, 3'h0, 3'b100);
    wreg(8'h00, 32'h0300_0200);
    wreg(8'h14, 32'h1303);
    issue(16'h0042, 3'h0, 3'b100);
    retire(5'h07, 4'h0, 1'b0);
    rreg(8'h20, 32'h1);
    $display("test replay tags done");
    for (k = 0; k < 6; k++) begin
      wreg(8'h18, 32'h310 | k);
      issue(16'h2000, k[2:0], 3'b001);
      `CHK(tval, 4'h1)
      issue(16'h2000, k[2:0] + 3'h1, 3'b000);
    end
    wreg(8'h18, 32'h301);
    issue(16'h2000, 3'h1, 3'b000);
    wreg(8'h18, 32'h367);
    issue(16'h6000, 3'h7, 3'b001);
    issue(16'hA000, 3'h7, 3'b001);
    wreg(8'h18, 32'h347);
    issue(16'h6000, 3'h7, 3'b000);
    $display("test exec tags done");
    wreg(8'h24, 32'h0);
    retire(5'h0B, 4'h0, 1'b0);
    retire(5'h09, 4'h0, 1'b0);
    rreg(8'h24, 32'h1);
    retire(5'h0B, 4'h0, 1'b1);
    rreg(8'h24, 32'h1);
    wreg(8'h1C, 32'h11);
    retire(5'h13, 4'h1, 1'b0);
    retire(5'h13, 4'h2, 1'b0);
    rreg(8'h28, 32'h1);
    wreg(8'h28, 32'h5);
    rreg(8'h28, 32'h0);
    $display("test retirement counts done");
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    conclude();
  end
endmodule
`default_nettype wire
